// ==== stcp_consts.svh ====
// Register offsets, field positions, reset values and timing counts of the timer
`ifndef STCP_CONSTS_SVH
`define STCP_CONSTS_SVH
// Register byte offsets
`define STCP_OFF_CTRL0     8'h00
`define STCP_OFF_CTRL1     8'h04
`define STCP_OFF_CNT       8'h08
`define STCP_OFF_CMPA      8'h0C
`define STCP_OFF_CMPA_HI   8'h10
`define STCP_OFF_STATUS    8'h14
// Control zero fields
`define STCP_C0_ON         3
`define STCP_C0_CMPP_HI    2
`define STCP_C0_CMPP_LO    0
// Control one fields
`define STCP_C1_MODE_HI    7
`define STCP_C1_MODE_LO    6
`define STCP_C1_PIN_HI     5
`define STCP_C1_PIN_LO     4
`define STCP_C1_OIL        3
`define STCP_C1_INV        2
`define STCP_C1_SWAP       1
`define STCP_C1_CLRSEL     0
// Status fields
`define STCP_ST_AF         0
`define STCP_ST_PF         1
`define STCP_ST_PIN        2
// Reset values and counter maximum
`define STCP_RST_CTRL      8'h00
`define STCP_RST_CMPA      10'h000
`define STCP_CNT_MAX       10'h3FF
// Timer clock: time of one tick in ns, and the period in cycles of hclk
`define STCP_CLK_NS        5
`define STCP_TICK_NS       20
`define STCP_TICK_CYC      ((`STCP_TICK_NS + `STCP_CLK_NS - 1) / `STCP_CLK_NS)
`endif

// ==== stcp_pkg.sv ====
// Types of the standard timer with compare and PWM
package stcp_pkg;
  typedef enum logic [1:0] {STCP_CMP = 2'b00, STCP_CAP = 2'b01,
                            STCP_PWM = 2'b10, STCP_TMR = 2'b11} stcp_mode_t;
  typedef enum logic [1:0] {STCP_BUS_IDLE, STCP_BUS_WR, STCP_BUS_RD} stcp_bus_t;
endpackage : stcp_pkg

// ==== stcp_tick.sv ====
// Divider making the one-cycle timer clock enable
`timescale 1ns/1ps
`include "stcp_consts.svh"
module stcp_tick
  import stcp_pkg::*;
#(
  parameter int DIV = `STCP_TICK_CYC
)(
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Enable pulse
  output logic      tick
);
  initial
  begin
    if (DIV < 1 || DIV > 65536) $error("stcp_tick: DIV must lie in 1 to 65536");
  end
  typedef struct packed
  {
    logic [15:0] cnt;   // Cycles since last pulse
    logic        tick;  // Registered enable
  } stcp_tick_st_t;
  stcp_tick_st_t st, next_st;
  // Count cycles, pulse on the last
  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == 16'(DIV - 1))
    begin
      next_st.cnt  = 16'h0000;
      next_st.tick = 1'b1;
    end
    else
      next_st.cnt = st.cnt + 16'h0001;
  end
  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st <= '0;
    else
      st <= next_st;
  end
  assign tick = st.tick;
endmodule : stcp_tick

// ==== stcp_timer.sv ====
// Standard timer: compare match, timer/counter and PWM, with AHB-Lite registers
//
// What this block does
// - Mode field 00 selects compare-match output
// - Clear-select low: P match/overflow clears, both flags
// - Clear-select high: A match clears, only A flag
// - Compare A zero: overflow at 3FF, no A flag
// - Compare mode: pin changes only on A match or enable rising
// - Pin function: none, low, high or toggle
// - Enable rising forces pin to initial level
// - Mode 11 behaves as compare, pin undriven
// - PWM output when mode and pin field 10
// - PWM ignores clear-select; swap picks period register
// - Swap zero: period P times 128, duty A
// - Swap one: period A, duty P times 128
// - Duty at or above period gives full duty
// - PWM raises A and P flags on matches
// - Pin field forces or enables; initial bit polarity
// - PWM counting runs while pin is forced
// - Invert bit inverts waveform before pin
// - Enable rising zeroes counter; falling holds count
// - Requested level equal to current: no change
//
// Limitations: capture and single-pulse modes are not served. Change the
// mode or pin field only while the counter is off; a running period would
// otherwise finish with an undefined waveform.
`timescale 1ns/1ps
`include "stcp_consts.svh"
module stcp_timer
  import stcp_pkg::*;
#(
  parameter int CW  = 10,              // Counter width
  parameter int DIV = `STCP_TICK_CYC   // hclk cycles per timer clock
)(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Timer output pin
  output logic             timer_out,
  output logic             timer_out_oe
);
  // Refuse parameters that the fixed-width logic cannot serve
  initial
  begin
    if (CW != 10) $error("stcp_timer: only a 10-bit counter is supported");
    if (DIV < 1 || DIV > 65536) $error("stcp_timer: DIV must lie in 1 to 65536");
  end

  // All state in one word: bus, registers, counter, flags and pin
  typedef struct packed
  {
    stcp_bus_t   bus;         // Data-phase kind
    logic [7:0]  addr;        // Latched address
    logic [31:0] rdata;       // Read data
    logic [7:0]  ctrl0;       // Enable and compare P
    logic [7:0]  ctrl1;       // Mode and pin control
    logic [9:0]  cmpa;        // Compare A value
    logic [9:0]  cnt;         // Counter
    logic        on_d;        // Enable seen last cycle
    logic        af;          // Match A flag
    logic        pf;          // Match P flag
    logic        cm_lvl;      // Compare-mode pin level
    logic        pwm_act;     // PWM waveform active
    logic        pin;         // Registered pin
    logic        oe;          // Registered enable
  } stcp_st_t;

  stcp_st_t st, next_st;
  logic     tick;             // Timer clock enable

  // Timer clock divider
  stcp_tick #(.DIV(DIV)) u_tick
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick)
  );

  // Period of P comparator in ticks, 0 means 1024
  // A zero field stands for the full counter range
  function automatic logic [10:0] stcp_p_ticks(input logic [2:0] p);
    stcp_p_ticks = (p == 3'b000) ? 11'h400 : {p, 8'h00} >> 1;
  endfunction : stcp_p_ticks

  // Status word, also used for the read mux
  // Unmapped places read as zero, so probing is harmless
  function automatic logic [31:0] stcp_rd(input stcp_st_t s, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      `STCP_OFF_CTRL0   : r = {24'h000000, s.ctrl0};
      `STCP_OFF_CTRL1   : r = {24'h000000, s.ctrl1};
      `STCP_OFF_CNT     : r = {22'h000000, s.cnt};
      `STCP_OFF_CMPA    : r = {24'h000000, s.cmpa[7:0]};
      `STCP_OFF_CMPA_HI : r = {30'h00000000, s.cmpa[9:8]};
      `STCP_OFF_STATUS  : r = {29'h00000000, s.pin, s.pf, s.af};
      default           : r = 32'h0000_0000;
    endcase
    stcp_rd = r;
  endfunction : stcp_rd

  // Decoded controls
  logic [1:0]  mode;          // Operating mode field
  logic [1:0]  pfn;           // Pin-function field
  logic [2:0]  cmpp;          // Compare P value
  logic        on;            // Count enable
  logic        oil;           // Output initial level
  logic        match_a;       // Comparator A equality
  logic        match_p;       // Comparator P equality
  logic        ovf;           // Counter at maximum
  logic [10:0] p_ticks;       // P expressed in ticks
  logic        bus_go;        // Valid address phase

  // Field decode and comparators, shared by all modes
  always_comb
  begin
    mode    = st.ctrl1[`STCP_C1_MODE_HI:`STCP_C1_MODE_LO];
    pfn     = st.ctrl1[`STCP_C1_PIN_HI:`STCP_C1_PIN_LO];
    cmpp    = st.ctrl0[`STCP_C0_CMPP_HI:`STCP_C0_CMPP_LO];
    on      = st.ctrl0[`STCP_C0_ON];
    oil     = st.ctrl1[`STCP_C1_OIL];
    p_ticks = stcp_p_ticks(cmpp);
    // Match fires on the tick that would reach the compared count
    match_a = (st.cmpa != 10'h000) && (st.cnt == st.cmpa - 10'h001);
    match_p = (cmpp != 3'b000) && ({1'b0, st.cnt} == p_ticks - 11'h001);
    ovf     = (st.cnt == `STCP_CNT_MAX);
    bus_go  = hsel && hready && htrans[1];
  end

  // Next state: bus, counter, flags and pin
  always_comb
  begin
    logic clr;                // Counter clear this tick
    logic set_a;              // A flag event
    logic set_p;              // P flag event
    logic [10:0] duty;        // PWM duty in ticks
    logic [10:0] per;         // PWM period in ticks
    logic        wave;        // PWM waveform before polarity
    clr   = 1'b0;
    set_a = 1'b0;
    set_p = 1'b0;
    duty  = 11'h000;
    per   = 11'h000;
    wave  = 1'b0;
    next_st = st;
    next_st.on_d = on;

    // Data phase of previous transfer; slave never waits
    next_st.bus = STCP_BUS_IDLE;
    if (st.bus == STCP_BUS_WR)
    begin
      unique case (st.addr)
        `STCP_OFF_CTRL0   : next_st.ctrl0 = {4'h0, hwdata[3:0]};
        `STCP_OFF_CTRL1   : next_st.ctrl1 = hwdata[7:0];
        `STCP_OFF_CMPA    : next_st.cmpa[7:0] = hwdata[7:0];
        `STCP_OFF_CMPA_HI : next_st.cmpa[9:8] = hwdata[1:0];
        default           : ;
      endcase
    end
    if (bus_go)
    begin
      next_st.addr  = haddr[7:0];
      next_st.bus   = hwrite ? STCP_BUS_WR : STCP_BUS_RD;
      // Read sees a write landing this cycle, so a read straight after a
      // write to a control or compare register returns the new value
      next_st.rdata = stcp_rd(next_st, haddr[7:0]);
    end

    // Counting and match events
    if (on && !st.on_d)
    begin
      next_st.cnt    = 10'h000;
      next_st.cm_lvl = oil;
      // PWM opens its first period in the active phase
      next_st.pwm_act = 1'b1;
    end
    else if (on && tick)
    begin
      if (mode == STCP_PWM)
      begin
        // Clear-select ignored; swap chooses the period register
        if (st.ctrl1[`STCP_C1_SWAP])
        begin
          per  = {1'b0, st.cmpa};
          duty = p_ticks;
          clr  = match_a;
        end
        else
        begin
          per  = p_ticks;
          duty = {1'b0, st.cmpa};
          clr  = (cmpp == 3'b000) ? ovf : match_p;
        end
        set_a = match_a;
        set_p = match_p;
        // Active from clear until duty; full duty when duty >= period
        if (clr)
          next_st.pwm_act = (duty != 11'h000);
        else if (duty < per && {1'b0, st.cnt} + 11'h001 == duty)
          next_st.pwm_act = 1'b0;
      end
      else if (mode == STCP_CMP || mode == STCP_TMR)
      begin
        if (st.ctrl1[`STCP_C1_CLRSEL])
        begin
          clr   = match_a || (st.cmpa == 10'h000 && ovf);
          set_a = match_a;
        end
        else
        begin
          clr   = (cmpp == 3'b000) ? ovf : match_p;
          set_a = match_a;
          set_p = match_p || (cmpp == 3'b000 && ovf);
        end
        // Pin moves only with the A flag; same level means no change
        if (set_a)
        begin
          unique case (pfn)
            2'b00 : ;
            2'b01 : next_st.cm_lvl = 1'b0;
            2'b10 : next_st.cm_lvl = 1'b1;
            2'b11 : next_st.cm_lvl = ~st.cm_lvl;
          endcase
        end
      end
      // Counter wraps on clear, else counts up
      next_st.cnt = clr ? 10'h000 : st.cnt + 10'h001;
    end
    // Disabling keeps the count (no branch taken)

    // Hardware set wins over a software clear in the same cycle
    if (st.bus == STCP_BUS_WR && st.addr == `STCP_OFF_STATUS)
    begin
      if (hwdata[`STCP_ST_AF])
        next_st.af = 1'b0;
      if (hwdata[`STCP_ST_PF])
        next_st.pf = 1'b0;
    end
    if (set_a)
      next_st.af = 1'b1;
    if (set_p)
      next_st.pf = 1'b1;

    // Pin drive per mode
    if (mode == STCP_PWM)
    begin
      unique case (pfn)
        2'b00   : wave = 1'b0;
        2'b01   : wave = 1'b1;
        2'b10   : wave = next_st.pwm_act;
        default : wave = 1'b0;
      endcase
      next_st.pin = (oil ? wave : ~wave) ^ st.ctrl1[`STCP_C1_INV];
      next_st.oe  = 1'b1;
    end
    else if (mode == STCP_CMP)
    begin
      next_st.pin = next_st.cm_lvl ^ st.ctrl1[`STCP_C1_INV];
      next_st.oe  = 1'b1;
    end
    else
    begin
      next_st.pin = 1'b0;
      next_st.oe  = 1'b0;
    end
  end

  // State register
  // Reset loads the power-on register values
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st       <= '0;
      st.bus   <= STCP_BUS_IDLE;
      st.ctrl0 <= `STCP_RST_CTRL;
      st.ctrl1 <= `STCP_RST_CTRL;
      st.cmpa  <= `STCP_RST_CMPA;
    end
    else
      st <= next_st;
  end

  // Read data and pin outputs straight from flip-flops
  // Bus answer is tied: the slave never waits and never errs
  assign hrdata       = st.rdata;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign timer_out    = st.pin;
  assign timer_out_oe = st.oe;
endmodule : stcp_timer

// ==== stcp_timer_properties.sv ====
// Checker of the timer's pin and bus behaviour, bound to stcp_timer
`timescale 1ns/1ps
module stcp_props (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  // Pin
  input wire logic        timer_out,
  input wire logic        timer_out_oe
);
  logic [7:0] aq;  // Address of the data phase
  logic       wq;  // Write data phase
  logic       rq;  // Read data phase
  logic [7:0] c0;  // Shadow of control zero
  logic [7:0] c1;  // Shadow of control one
  // Shadows follow bus writes at the same edge as the design's registers
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      {aq, wq, rq, c0, c1} <= '0;
    end
    else
    begin
      if (hready)
      begin
        aq <= haddr[7:0];
        wq <= hsel && htrans[1] && hwrite;
        rq <= hsel && htrans[1] && !hwrite;
      end
      if (wq && aq == 8'h00)
        c0 <= hwdata[7:0];
      if (wq && aq == 8'h04)
        c1 <= hwdata[7:0];
    end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Three settled cycles hide the register's own delay
  a_oe_compare :
    assert property ((c1[7:6] == 2'b00) [*3] |-> timer_out_oe) else $error("Pin idle in compare");
  a_pin_hold :
    assert property ((c1[7:4] == 4'h0 && c0[3] && $stable(c1) && $stable(c0)) [*3]
      |=> $stable(timer_out)) else $error("Pin moved with no action");
  a_enable_init :
    assert property (c1[7:6] == 2'b00 && $rose(c0[3]) |-> ##[0:1] timer_out == (c1[3] ^ c1[2]))
      else $error("Pin not at initial level");
  a_timer_pin :
    assert property ((c1[7:6] == 2'b11) [*3] |-> !timer_out_oe && !timer_out)
      else $error("Pin driven in timer mode");
  a_oe_pwm :
    assert property ((c1[7:6] == 2'b10) [*3] |-> timer_out_oe) else $error("Pin idle in PWM");
  a_pwm_inactive :
    assert property ((c1[7:4] == 4'h8 && c0[3]) [*3] |-> timer_out == (!c1[3] ^ c1[2]))
      else $error("Forced inactive level wrong");
  a_pwm_active :
    assert property ((c1[7:4] == 4'h9 && c0[3]) [*3] |-> timer_out == (c1[3] ^ c1[2]))
      else $error("Forced active level wrong");
  a_cnt_width :
    assert property (rq && aq == 8'h08 |-> hrdata[31:10] == 22'h0) else $error("Count too wide");
endmodule : stcp_props
bind stcp_timer stcp_props stcp_props_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hrdata(hrdata), .timer_out(timer_out), .timer_out_oe(timer_out_oe));

// ==== test_stcp_timer.sv ====
// Self-checking bench of the timer: counter periods, flags and pin duty
`timescale 1ns/1ps
`include "stcp_consts.svh"
module test_stcp_timer;
  logic        hclk = 0;      // Bus clock
  logic        hresetn = 0;   // Reset, active low
  logic        hsel = 0;      // Bus inputs
  logic [31:0] haddr = 0;
  logic [1:0]  htrans = 0;
  logic        hwrite = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] hrdata;        // Bus outputs
  logic        hreadyout;
  logic        hresp;
  logic        timer_out;     // Pin
  logic        timer_out_oe;
  logic [31:0] q, p, r;       // Read values and random write data
  int          miscompares = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          n, hi;
  int          mper, mhi, mfl;  // Model results
  // Control one, compare P, compare A, period, highs in two periods, flags
  int cfg [11][6] = '{'{8'h08, 1, 5, 128, 256, 3}, '{8'h00, 0, 5, 1024, 0, 3},
    '{8'h31, 1, 200, 200, 200, 1}, '{8'hC1, 0, 0, 1024, 0, 0}, '{8'hC0, 2, 5, 256, 0, 3},
    '{8'hA9, 1, 50, 128, 100, 3}, '{8'hAA, 1, 300, 300, 256, 3}, '{8'hA8, 1, 200, 128, 256, 2},
    '{8'hAC, 2, 64, 256, 384, 3}, '{8'h88, 1, 50, 128, 0, 3}, '{8'h98, 1, 50, 128, 256, 3}};

  // One tick per cycle keeps the long periods short to run
  stcp_timer #(.DIV(1)) stcp_timer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_out(timer_out), .timer_out_oe(timer_out_oe));

  always #2.5 hclk = ~hclk;

  // Hang guard
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Rule model: period, pin highs over two periods and flags of one setting
  function automatic void model(input int c1, input int cp, input int ca,
                                output int per, output int hi, output int fl);
    int mode, pfn, lvl, pt, duty;
    mode = (c1 >> 6) & 3;
    pfn  = (c1 >> 4) & 3;
    lvl  = ((c1 >> 3) ^ (c1 >> 2)) & 1;
    pt   = (cp == 0) ? 1024 : cp * 128;
    if (mode == 2)
    begin
      per  = (c1 & 2) ? ca : pt;
      duty = (c1 & 2) ? pt : ca;
      duty = (duty >= per) ? per : duty;
      if (pfn != 2)
        duty = (pfn == 1) ? per : 0;
      hi   = 2 * (lvl ? duty : per - duty);
      fl   = ((ca != 0 && ca <= per) ? 1 : 0) + ((cp != 0 && pt <= per) ? 2 : 0);
    end
    else
    begin
      per  = (c1 & 1) ? ((ca == 0) ? 1024 : ca) : pt;
      fl   = ((ca != 0 && ca <= per) ? 1 : 0) + ((c1 & 1) ? 0 : 2);
      case (pfn)
        0       : hi = lvl ? 2 * per : 0;
        1       : hi = (c1 & 4) ? 2 * per : 0;
        2       : hi = (c1 & 4) ? 0 : 2 * per;
        default : hi = per;
      endcase
      if (mode == 3)
        hi = 0;
    end
  endfunction : model

  // One single transfer; entered just after a rising edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd_data);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_data = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    ahb(1'b1, a, d, unused);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ahb(1'b0, a, 32'h0, d);
  endtask : rd

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  initial
  begin
    void'($urandom(28981));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, unmapped place last
    for (int a = 0; a <= 8'h18; a += 4)
    begin
      rd(a[7:0], q);
      chk(q, 32'h0);
    end
    chk(hresp, 1'b0);
    // Random compare A, only ten bits kept
    r = $urandom;
    wr(`STCP_OFF_CMPA, r);
    wr(`STCP_OFF_CMPA_HI, r >> 8);
    wr(8'h18, r);
    rd(`STCP_OFF_CMPA, q);
    chk(q, {24'h0, r[7:0]});
    rd(`STCP_OFF_CMPA_HI, q);
    chk(q, {30'h0, r[9:8]});
    rd(8'h18, q);
    chk(q, 32'h0);
    // Each mode setting: period, pin highs, flags, stop
    foreach (cfg[i])
    begin
      wr(`STCP_OFF_CTRL0, 32'h0);
      wr(`STCP_OFF_CTRL1, cfg[i][0]);
      wr(`STCP_OFF_CMPA, cfg[i][2]);
      wr(`STCP_OFF_CMPA_HI, cfg[i][2] >> 8);
      wr(`STCP_OFF_STATUS, 32'h3);
      wr(`STCP_OFF_CTRL0, 8 + cfg[i][1]);
      model(cfg[i][0], cfg[i][1], cfg[i][2], mper, mhi, mfl);
      n = mper;
      chk(n, cfg[i][3]);
      // Counter is zeroed one cycle after the enable lands
      @(posedge hclk);
      rd(`STCP_OFF_CNT, q);
      chk(q, 32'h0);
      // Reads two cycles apart: count steps by two, wraps at the period
      repeat (n / 2 + 8)
      begin
        p = q;
        rd(`STCP_OFF_CNT, q);
        chk(q < n, 32'h1);
        chk((q - p + n) % n, 32'h2);
      end
      hi = 0;
      repeat (2 * n)
      begin
        @(posedge hclk);
        hi += (timer_out === 1'b1);
      end
      chk(hi, cfg[i][4]);
      chk(hi, mhi);
      chk(timer_out_oe, cfg[i][0][7:6] != 2'b11);
      rd(`STCP_OFF_STATUS, q);
      chk(q & 32'h3, cfg[i][5]);
      chk(q & 32'h3, mfl);
      wr(`STCP_OFF_CTRL0, cfg[i][1]);
      rd(`STCP_OFF_CNT, p);
      rd(`STCP_OFF_CNT, q);
      chk(q, p);
    end
    finish_test();
  end
endmodule : test_stcp_timer
